// *** cks_key_filter.sv ***
// debounces one active-high key level and classifies presses
// assumes key level is synchronous to clk
`timescale 1ns/10ps
module cks_key_filter
    import cks_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int LONG_CYCLES = HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic keyLevel,
    cks_key_if.source ev
);
    logic stable, next_stable;
    logic [31:0] debCnt, next_debCnt;
    logic [31:0] holdCnt, next_holdCnt;
    logic longDone, next_longDone;
    logic shortP, next_shortP, longP, next_longP;

    // filter, then time the press; short fires on release only
    always_comb begin
        next_stable = stable;
        next_debCnt = 32'h0;
        next_holdCnt = holdCnt;
        next_longDone = longDone;
        next_shortP = 1'b0;
        next_longP = 1'b0;
        if (keyLevel != stable) begin
            next_debCnt = debCnt + 32'h1;
            if (debCnt >= 32'(DEB_CYCLES - 1)) begin
                next_stable = keyLevel;
                next_debCnt = 32'h0;
                if (!keyLevel && !longDone) next_shortP = 1'b1;
            end
        end
        if (stable) begin
            if (!longDone) next_holdCnt = holdCnt + 32'h1;
            if (!longDone && holdCnt >= 32'(LONG_CYCLES - 1)) begin
                next_longP = 1'b1;
                next_longDone = 1'b1;
            end
        end else begin
            next_holdCnt = 32'h0;
            next_longDone = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stable <= 1'b0;
            debCnt <= 32'h0;
            holdCnt <= 32'h0;
            longDone <= 1'b0;
            shortP <= 1'b0;
            longP <= 1'b0;
        end else if (ce) begin
            stable <= next_stable;
            debCnt <= next_debCnt;
            holdCnt <= next_holdCnt;
            longDone <= next_longDone;
            shortP <= next_shortP;
            longP <= next_longP;
        end
    end

    assign ev.shortPress = shortP;
    assign ev.longPress = longP;
endmodule // cks_key_filter

// *** cks_key_if.sv ***
// key event carrier between the debouncer and the sequencer
// assumes a single clock domain
`timescale 1ns/10ps
interface cks_key_if;
    logic shortPress;
    logic longPress;
    modport source (output shortPress, output longPress);
    modport sink (input shortPress, input longPress);
endinterface // cks_key_if

// *** cks_operator_model.sv ***
// operator model: buttons that short to ground while pressed
// assumes callers start a press between clock edges
`timescale 1ns/10ps
module cks_operator_model (
    input wire logic clk,
    output logic [2:0] keys_n
);
    // idle keys rest at the pull-up level
    initial keys_n = 3'h7;
    // hold one key low; bit 2 is the control system input
    task automatic press(input int k, input int n);
        @(negedge clk) keys_n[k] = 1'b0;
        repeat (n) @(negedge clk);
        keys_n[k] = 1'b1;
    endtask
endmodule // cks_operator_model

// *** cks_pkg.sv ***
// package for the calibration key sequencer: timing, codes, states
// assumes a 40 MHz clock; nothing else
package cks_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int HOLD_MS = 2000;            // long-press threshold
    localparam int HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;
    localparam int DEBOUNCE_MS = 20;
    localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int BLINK_MS = 250;            // equal on and off phase
    localparam int BLINK_CYCLES = CLK_HZ / 1000 * BLINK_MS;
    localparam logic [3:0] BLINKS_GAIN = 4'h2;
    localparam logic [3:0] BLINKS_OFFSET = 4'h4;
    localparam logic [3:0] BLINKS_SAVE = 4'h1;
    localparam logic [3:0] BLINKS_AUTO = 4'h6;
    localparam int VAL_W = 8;
    localparam int COARSE_W = 4;              // coarse step is 1 << COARSE_W
    localparam logic [VAL_W-1:0] ZERO_OUT = 8'h80;  // code for 5,0 V output
    localparam logic [VAL_W-1:0] FINE_STEP = 8'h01;
    localparam logic [VAL_W-1:0] COARSE_STEP = 8'h10;
    typedef enum {ST_NORMAL, ST_GAIN, ST_OFFSET} cks_mode_type;
endpackage

// *** cks_properties.sv ***
// port checker for the calibration key sequencer
// assumes ce is high whenever the lamp or the defect input moves
`timescale 1ns/10ps
module cks_properties
    import cks_pkg::*;
#(
    parameter int BLINK_LEN = BLINK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic defectDetected,
    input wire logic [3:0] speedScaleCode,
    input wire logic [VAL_W-1:0] activeGain,
    input wire logic storeStrobe,
    input wire logic programIndicator,
    input wire logic faultIndicator,
    input wire logic errorSignal,
    input wire logic [13:0] fullScaleRpm,
    input wire logic [9:0] rpmPerVolt,
    input wire logic [1:0] calMode
);
    int onLen;
    int next_onLen;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // cycles the lamp has stood on so far
    always_comb next_onLen = programIndicator ? onLen + 1 : 0;
    always_ff @(posedge clk) onLen <= nrst ? next_onLen : 0;
    chk_fault_follow: assert property ($past(nrst) |->
        faultIndicator == $past(defectDetected)) else $error("fault lamp lags");
    chk_error_lamp: assert property (errorSignal == faultIndicator)
        else $error("error signal differs from fault lamp");
    chk_scale_ratio: assert property ($past(nrst) &&
        $stable(speedScaleCode) |-> rpmPerVolt * 10 == fullScaleRpm)
        else $error("rpm per volt not a tenth of full scale");
    chk_strobe_once: assert property (storeStrobe |=> !storeStrobe)
        else $error("store strobe longer than one cycle");
    chk_strobe_blink: assert property (storeStrobe |->
        ##[0:2] programIndicator) else $error("store not confirmed by lamp");
    chk_mode_order: assert property ($past(nrst) &&
        calMode != $past(calMode) |->
        calMode == ($past(calMode) == 2'h2 ? 2'h0 : $past(calMode) + 2'h1))
        else $error("illegal mode step");
    chk_gain_blink: assert property (calMode == 2'h1 &&
        $past(calMode) == 2'h0 |-> ##[0:2] programIndicator)
        else $error("gain entry not shown");
    chk_blink_hold: assert property (programIndicator && $past(programIndicator)
        |-> $stable(activeGain) && $stable(calMode))
        else $error("key acted during blink");
    chk_blink_len: assert property ($past(nrst) && $fell(programIndicator)
        |-> onLen == BLINK_LEN) else $error("lamp on-phase length wrong");
    cover property (storeStrobe);
    cover property (calMode == 2'h2);
    cover property (faultIndicator);
endmodule // cks_properties
bind cks_sequencer cks_properties #(.BLINK_LEN(BLINK_LEN)) cks_properties_i (
    .clk(clk), .nrst(nrst), .defectDetected(defectDetected),
    .speedScaleCode(speedScaleCode), .activeGain(activeGain),
    .storeStrobe(storeStrobe), .programIndicator(programIndicator),
    .faultIndicator(faultIndicator), .errorSignal(errorSignal),
    .fullScaleRpm(fullScaleRpm), .rpmPerVolt(rpmPerVolt), .calMode(calMode));

// *** cks_sequencer.sv ***
// calibration key sequencer: modes, value stepping, blink confirm, scale
// assumes synchronous inputs; the non-volatile store sits outside and
// takes storedGain/storedOffset when storeStrobe pulses
// Function
// - long program press: gain mode, two blinks
// - gain mode: offset key coarse, program fine
// - long program press in gain: offset, four blinks
// - offset mode: coarse and fine stepping alike
// - long program press in offset: store, one blink
// - long offset press: automatic zero alignment
// - auto zero: store, six blinks, resume
// - external auto-zero input acts as offset key
// - power cycle discards unsaved adjustments
// - stored values kept in non-volatile storage
// - fault indicator and error follow defect
// - four-bit code selects full-scale speed
`timescale 1ns/10ps
module cks_sequencer
    import cks_pkg::*;
#(
    parameter int DEB_CYCLES = DEBOUNCE_CYCLES,
    parameter int LONG_CYCLES = HOLD_CYCLES,
    parameter int BLINK_LEN = BLINK_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic offsetKey_n,
    input wire logic autoZeroKey_n,
    input wire logic programKey_n,
    input wire logic [VAL_W-1:0] nvGain,
    input wire logic [VAL_W-1:0] nvOffset,
    input wire logic [VAL_W-1:0] zeroReading,
    input wire logic defectDetected,
    input wire logic [3:0] speedScaleCode,
    output logic [VAL_W-1:0] activeGain,
    output logic [VAL_W-1:0] activeOffset,
    output logic [VAL_W-1:0] storedGain,
    output logic [VAL_W-1:0] storedOffset,
    output logic storeStrobe,
    output logic programIndicator,
    output logic faultIndicator,
    output logic errorSignal,
    output logic [13:0] fullScaleRpm,
    output logic [9:0] rpmPerVolt,
    output logic [1:0] calMode
);
    cks_key_if offKeyEv();
    cks_key_if progKeyEv();

    // both sources pull low; either one counts as the offset key
    logic offLevel;
    assign offLevel = !offsetKey_n || !autoZeroKey_n;

    cks_key_filter #(.DEB_CYCLES(DEB_CYCLES), .LONG_CYCLES(LONG_CYCLES))
    uOffKey (
        .clk(clk), .nrst(nrst), .ce(ce),
        .keyLevel(offLevel), .ev(offKeyEv.source)
    );
    cks_key_filter #(.DEB_CYCLES(DEB_CYCLES), .LONG_CYCLES(LONG_CYCLES))
    uProgKey (
        .clk(clk), .nrst(nrst), .ce(ce),
        .keyLevel(!programKey_n), .ev(progKeyEv.source)
    );

    // full-scale table: base digit times decade
    function automatic logic [13:0] scaleRpm(input logic [3:0] c);
        logic [13:0] base;
        logic [13:0] dec;
        base = 14'h0;
        dec = 14'h1;
        case (c[1:0])
            2'h0: base = (c[3:2] == 2'h0) ? 14'h1 : 14'h6;
            2'h1: base = (c[3:2] == 2'h0) ? 14'h2 : 14'h8;
            2'h2: base = (c[3:2] == 2'h0) ? 14'h4 : 14'hA;
            default: base = (c[3:2] == 2'h0) ? 14'h6 : 14'h14;
        endcase
        if (c == 4'h4) base = 14'h8;
        if (c == 4'h5) base = 14'hA;
        if (c == 4'h6) base = 14'h14;
        if (c == 4'h7) base = 14'h28;
        if (c[3:2] == 2'h2) dec = 14'hA;
        if (c[3:2] == 2'h3) dec = 14'h64;
        if (c == 4'hC) base = 14'h4;
        if (c == 4'hD) base = 14'h6;
        if (c == 4'hE) base = 14'h8;
        if (c == 4'hF) base = 14'hA;
        return 14'(base * dec * 14'hA);
    endfunction

    cks_mode_type mode, next_mode;
    logic [VAL_W-1:0] gain, next_gain, offs, next_offs;
    logic [VAL_W-1:0] sGain, next_sGain, sOffs, next_sOffs;
    logic store, next_store;
    logic loaded, next_loaded;
    logic [3:0] blinksLeft, next_blinksLeft;
    logic blinkOn, next_blinkOn;
    logic [31:0] blinkCnt, next_blinkCnt;
    logic fault, next_fault;
    logic [13:0] fsRpm, next_fsRpm;
    logic [9:0] rpv, next_rpv;
    logic [1:0] cm, next_cm;
    logic busy;

    assign busy = (blinksLeft != 4'h0);

    // mode sequencing and value stepping; keys ignored while blinking
    always_comb begin
        next_mode = mode;
        next_gain = gain;
        next_offs = offs;
        next_sGain = sGain;
        next_sOffs = sOffs;
        next_store = 1'b0;
        next_loaded = 1'b1;
        next_blinksLeft = blinksLeft;
        next_blinkOn = blinkOn;
        next_blinkCnt = blinkCnt;
        if (!loaded) begin
            // after power-up the saved pair is reloaded, work is lost
            next_gain = nvGain;
            next_offs = nvOffset;
            next_sGain = nvGain;
            next_sOffs = nvOffset;
        end else if (busy) begin
            // equal on and off phases, one count per full blink
            if (blinkCnt >= 32'(BLINK_LEN - 1)) begin
                next_blinkCnt = 32'h0;
                next_blinkOn = !blinkOn;
                if (!blinkOn) begin
                    // a blink ends with its dark phase; stay dark after last
                    next_blinksLeft = blinksLeft - 4'h1;
                    next_blinkOn = (blinksLeft != 4'h1);
                end
            end else begin
                next_blinkCnt = blinkCnt + 32'h1;
            end
        end else begin
            next_blinkCnt = 32'h0;
            case (mode)
                ST_NORMAL: begin
                    if (progKeyEv.longPress) begin
                        next_mode = ST_GAIN;
                        next_blinksLeft = BLINKS_GAIN;
                    end else if (offKeyEv.longPress) begin
                        // trim offset so the idle reading lands on zero
                        next_offs = VAL_W'(offs + ZERO_OUT - zeroReading);
                        next_sOffs = VAL_W'(offs + ZERO_OUT - zeroReading);
                        next_sGain = gain;
                        next_store = 1'b1;
                        next_blinksLeft = BLINKS_AUTO;
                    end
                end
                ST_GAIN: begin
                    if (progKeyEv.longPress) begin
                        next_mode = ST_OFFSET;
                        next_blinksLeft = BLINKS_OFFSET;
                    end else if (offKeyEv.shortPress) begin
                        next_gain = gain + COARSE_STEP;
                    end else if (progKeyEv.shortPress) begin
                        next_gain = gain + FINE_STEP;
                    end
                end
                ST_OFFSET: begin
                    if (progKeyEv.longPress) begin
                        next_sGain = gain;
                        next_sOffs = offs;
                        next_store = 1'b1;
                        next_mode = ST_NORMAL;
                        next_blinksLeft = BLINKS_SAVE;
                    end else if (offKeyEv.shortPress) begin
                        next_offs = offs + COARSE_STEP;
                    end else if (progKeyEv.shortPress) begin
                        next_offs = offs + FINE_STEP;
                    end
                end
                default: next_mode = ST_NORMAL;
            endcase
            // lamp lights with the action so the confirm starts at once
            next_blinkOn = (next_blinksLeft != 4'h0);
        end
    end

    // fault lamp and speed scaling follow their inputs each cycle
    always_comb begin
        next_fault = defectDetected;
        next_fsRpm = scaleRpm(speedScaleCode);
        next_rpv = 10'(next_fsRpm / 14'hA);
        // mode code is registered so the port comes from a flop
        case (next_mode)
            ST_GAIN: next_cm = 2'h1;
            ST_OFFSET: next_cm = 2'h2;
            default: next_cm = 2'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode <= ST_NORMAL;
            gain <= '0;
            offs <= '0;
            sGain <= '0;
            sOffs <= '0;
            store <= 1'b0;
            loaded <= 1'b0;
            blinksLeft <= 4'h0;
            blinkOn <= 1'b0;
            blinkCnt <= 32'h0;
            fault <= 1'b0;
            fsRpm <= 14'h0;
            rpv <= 10'h0;
            cm <= 2'h0;
        end else if (ce) begin
            mode <= next_mode;
            gain <= next_gain;
            offs <= next_offs;
            sGain <= next_sGain;
            sOffs <= next_sOffs;
            store <= next_store;
            loaded <= next_loaded;
            blinksLeft <= next_blinksLeft;
            blinkOn <= next_blinkOn;
            blinkCnt <= next_blinkCnt;
            fault <= next_fault;
            fsRpm <= next_fsRpm;
            rpv <= next_rpv;
            cm <= next_cm;
        end
    end

    assign activeGain = gain;
    assign activeOffset = offs;
    assign storedGain = sGain;
    assign storedOffset = sOffs;
    assign storeStrobe = store;
    assign programIndicator = blinkOn;
    assign faultIndicator = fault;
    assign errorSignal = fault;
    assign fullScaleRpm = fsRpm;
    assign rpmPerVolt = rpv;
    assign calMode = cm;
endmodule // cks_sequencer

// *** cks_sequencer_tb.sv ***
// self-checking bench for the calibration key sequencer
// assumes the operator model drives keys; the nv store is modelled here
`timescale 1ns/10ps
module cks_sequencer_tb;
    import cks_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic defect = 1'b0;
    logic [7:0] nvG = 8'h35;
    logic [7:0] nvO = 8'h42;
    logic [3:0] code = 4'h0;
    logic ce = 1'b1;
    logic [7:0] zero = 8'h7A;
    logic [15:0] expO;
    logic [7:0] aG, aO, sG, sO;
    logic strobe, lamp, fault, err, prev;
    logic [13:0] fs;
    logic [9:0] pv;
    logic [1:0] mode;
    logic [2:0] keys_n;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int blinks;
    int rpm [16] = '{10, 20, 40, 60, 80, 100, 200, 400, 600, 800, 1000,
        2000, 4000, 6000, 8000, 10000};
    always #12.5 clk = ~clk;
    // the store keeps whatever the strobe hands over
    always @(posedge clk) if (strobe) {nvG, nvO} <= {sG, sO};
    cks_sequencer #(.DEB_CYCLES(4), .LONG_CYCLES(20), .BLINK_LEN(5))
        cks_sequencer_i (.clk(clk), .nrst(nrst), .ce(ce),
        .offsetKey_n(keys_n[0]), .programKey_n(keys_n[1]),
        .autoZeroKey_n(keys_n[2]), .nvGain(nvG), .nvOffset(nvO),
        .zeroReading(zero), .defectDetected(defect),
        .speedScaleCode(code), .activeGain(aG), .activeOffset(aO),
        .storedGain(sG), .storedOffset(sO), .storeStrobe(strobe),
        .programIndicator(lamp), .faultIndicator(fault),
        .errorSignal(err), .fullScaleRpm(fs), .rpmPerVolt(pv),
        .calMode(mode));
    cks_operator_model cks_operator_model_i (.clk(clk), .keys_n(keys_n));
    // hang guard: the tests need under 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
    task automatic check(input string what, input logic [15:0] e,
        input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    // press a key; count lamp blinks over a window fitting six of them
    task automatic op(input int k, input int n);
        blinks = 0;
        prev = 1'b0;
        fork
            cks_operator_model_i.press(k, n);
            repeat (110) begin
                @(negedge clk);
                if (lamp && !prev) blinks++;
                prev = lamp;
            end
        join
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check("gain load", 16'h3542, {aG, aO});
        for (int c = 0; c < 16; c++) begin
            code = c[3:0];
            repeat (2) @(negedge clk);
            check("full scale", rpm[c][15:0], {2'h0, fs});
            check("per volt", 16'(rpm[c] / 10), {6'h0, pv});
        end
        defect = 1'b1;
        repeat (2) @(negedge clk);
        check("fault on", 16'h3, {14'h0, fault, err});
        defect = 1'b0;
        repeat (2) @(negedge clk);
        check("fault off", 16'h0, {14'h0, fault, err});
        $display("test scale and fault done");
        // a frozen block must ignore a full long press
        ce = 1'b0;
        op(1, 30);
        ce = 1'b1;
        check("frozen", 16'h0, {6'h0, mode, blinks[7:0]});
        $display("test clock enable done");
        op(1, 30);
        check("gain mode", 16'h0102, {6'h0, mode, blinks[7:0]});
        op(0, 8);
        op(1, 8);
        check("gain steps", 16'h46, {8'h0, aG});
        op(1, 30);
        check("offset mode", 16'h0204, {6'h0, mode, blinks[7:0]});
        op(0, 8);
        op(1, 8);
        check("offset steps", 16'h53, {8'h0, aO});
        op(1, 30);
        check("save", 16'h0001, {6'h0, mode, blinks[7:0]});
        check("saved", 16'h4653, {nvG, nvO});
        $display("test manual done");
        op(1, 30);
        op(0, 8);
        nrst = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check("power cycle", 16'h4653, {aG, aO});
        check("power mode", 16'h0, {14'h0, mode});
        $display("test power cycle done");
        // second run reads above zero, so the offset must drop by four
        for (int k = 0; k < 3; k += 2) begin
            zero = (k == 0) ? 8'h7A : 8'h84;
            expO = (k == 0) ? 16'h59 : 16'h55;
            op(k, 30);
            check("auto blinks", 16'h6, blinks[15:0]);
            check("auto offset", expO, {8'h0, aO});
            check("auto saved", expO, {8'h0, nvO});
        end
        $display("test auto zero done");
        summarize();
    end
endmodule // cks_sequencer_tb
